// ### hw/pmc_coder.sv
// Peak mode classifier and peak position / gain coder
`timescale 1ns/1ns
`default_nettype none
module pmc_coder #(
	parameter int MAX_PEAKS = pmc_pkg::MAX_PEAKS_DEF
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic srst,
	// Frame control
	input wire logic frame_start,
	input wire logic rate_hi,
	input wire logic super_wideband,
	input wire logic [7:0] mode_count,
	input wire logic [7:0] sharp_lo_cnt,
	input wire logic [7:0] sharp_hi_cnt,
	// Coefficient stream
	input wire logic coef_valid,
	output logic coef_ready,
	input wire logic [pmc_pkg::MAG_W-1:0] coef_mag,
	input wire logic coef_neg,
	// Sub-band norm stream
	input wire logic norm_valid,
	output logic norm_ready,
	input wire logic [23:0] norm_energy,
	input wire logic [4:0] norm_q,
	// Frame results
	output logic frame_done,
	output pmc_pkg::pmc_mode_e frame_mode,
	output logic [15:0] limit_factor,
	output logic [4:0] top_band,
	output logic [5:0] peak_count,
	output logic [15:0] noise_floor_gain0,
	output logic [15:0] noise_floor_gain1,
	output logic [15:0] peak_energy_gain0,
	output logic [15:0] peak_energy_gain1,
	output logic sparse_sel,
	// Adjusted norm readback
	input wire logic [4:0] norm_rd_idx,
	output logic [4:0] norm_rd_q,
	// Code word stream
	output logic code_valid,
	input wire logic code_ready,
	output logic [pmc_pkg::CODE_W-1:0] code_data
);
	import pmc_pkg::*;

	typedef enum logic [3:0] {ST_IDLE, ST_LOAD, ST_NORM, ST_BAND, ST_GAIN, ST_SCAN, ST_PLACE,
		ST_HARM, ST_DEC, ST_COST, ST_EMITP, ST_EMITG, ST_DONE} pmc_state_e;

	pmc_state_e st_ff;
	logic rate_ff, swb_ff;
	logic [8:0] idx_ff, len, last_grp;
	logic [3:0] band_ff, nb;
	logic [15:0] mag_mem [LEN_HI];
	logic neg_mem [LEN_HI];
	logic [23:0] thr_mem [LEN_HI];
	logic [15:0] ne_trk_ff, pe_trk_ff, nxt_ne, nxt_pe, bmax_ff;
	logic [20:0] ne_sum_ff, pe_sum_ff;
	logic [15:0] ne_band [NB_HI];
	logic [15:0] pe_band [NB_HI];
	logic [15:0] xmax_band [NB_HI];
	logic [23:0] nrg_mem [NORM_CNT];
	logic [4:0] nq_mem [NORM_CNT];
	logic [3:0] n_sharp_ff;
	logic signed [19:0] d_sharp_ff;
	logic [LEN_HI-1:0] picked_ff;
	logic [5:0] npk_ff;
	logic [15:0] best_val_ff;
	logic [8:0] best_pos_ff, prev_pos_ff, gap_max_ff;
	logic found_ff, first_ff;
	logic [28:0] el_ff, et_ff;
	logic [4:0] hb_ff, prev_q_ff;
	logic [15:0] cost_d_ff;
	logic [7:0] grp_cnt_ff;
	logic coef_take, norm_take, in_valid, in_ready;
	logic [CODE_W-1:0] in_data;

	// Rate dependent span
	assign len = rate_ff ? 9'(LEN_HI) : 9'(LEN_LO);
	assign nb = rate_ff ? 4'(NB_HI) : 4'(NB_LO);
	assign last_grp = 9'((len + 9'(GRP_LEN - 1)) / 9'(GRP_LEN) - 9'd1);
	assign coef_ready = (st_ff == ST_LOAD);
	assign norm_ready = (st_ff == ST_NORM);
	assign coef_take = coef_valid && coef_ready;
	assign norm_take = norm_valid && norm_ready;

	// First-order smoother with rise/fall-dependent weight in Q15
	function automatic logic [15:0] trk(input logic [15:0] p, input logic [15:0] m,
		input logic [15:0] wu, input logic [15:0] wd);
		logic [15:0] w;
		logic [32:0] s;
		w = (m > p) ? wu : wd;
		s = 33'(32'(w) * 32'(p)) + 33'(32'(Q15_ONE - w) * 32'(m));
		return s[30:15];
	endfunction

	// Compact code for a 5-bin group with peaks at least 3 apart
	function automatic logic [2:0] grp_code(input logic [4:0] g);
		logic [2:0] c;
		c = 3'h0;
		for (int i = 0; i < GRP_LEN; i++) if (g == 5'(1 << i)) c = 3'(i);
		if (g == 5'h09) c = 3'h5;
		if (g == 5'h11) c = 3'h6;
		if (g == 5'h12) c = 3'h7;
		return c;
	endfunction

	assign nxt_ne = trk(ne_trk_ff, coef_mag, NE_W_UP, NE_W_DN);
	assign nxt_pe = trk(pe_trk_ff, coef_mag, PE_W_UP, PE_W_DN);

	// Frame sequencer
	always_ff @(posedge mclk) begin
		if (srst) begin
			st_ff <= ST_IDLE;
			idx_ff <= 9'h000;
		end else begin
			unique case (st_ff)
				ST_IDLE: if (frame_start) begin
					st_ff <= ST_LOAD;
					idx_ff <= 9'h000;
				end
				ST_LOAD: if (coef_take) begin
					idx_ff <= (idx_ff == len - 9'd1) ? 9'h000 : idx_ff + 9'd1;
					if (idx_ff == len - 9'd1) st_ff <= ST_NORM;
				end
				ST_NORM: if (norm_take) begin
					idx_ff <= (idx_ff == 9'(NORM_CNT - 1)) ? 9'h000 : idx_ff + 9'd1;
					if (idx_ff == 9'(NORM_CNT - 1)) st_ff <= ST_BAND;
				end
				ST_BAND: if (band_ff == nb - 4'd1) st_ff <= ST_GAIN;
				ST_GAIN: st_ff <= ST_SCAN;
				ST_SCAN: begin
					idx_ff <= (idx_ff == len - 9'd1) ? 9'h000 : idx_ff + 9'd1;
					if (idx_ff == len - 9'd1) st_ff <= ST_PLACE;
				end
				ST_PLACE: st_ff <= (found_ff && npk_ff < 6'(MAX_PEAKS)) ? ST_SCAN : ST_HARM;
				ST_HARM: if (hb_ff > NORM_LAST || (44'(el_ff) << 15) >= 44'(et_ff) * 44'(limit_sel()))
					st_ff <= ST_DEC;
				ST_DEC: st_ff <= pvq_now() ? ST_COST : ST_DONE;
				ST_COST: begin
					idx_ff <= (idx_ff == len - 9'd1) ? 9'h000 : idx_ff + 9'd1;
					if (idx_ff == len - 9'd1) st_ff <= ST_EMITP;
				end
				ST_EMITP: if (!picked_ff[idx_ff] || in_ready) begin
					idx_ff <= (idx_ff == len - 9'd1) ? 9'h000 : idx_ff + 9'd1;
					if (idx_ff == len - 9'd1) st_ff <= sparse_sel ? ST_EMITG : ST_DONE;
				end
				ST_EMITG: if (in_ready) begin
					idx_ff <= (idx_ff == last_grp) ? 9'h000 : idx_ff + 9'd1;
					if (idx_ff == last_grp) st_ff <= ST_DONE;
				end
				ST_DONE: st_ff <= ST_IDLE;
			endcase
		end
	end

	// Limitation factor for the current rate
	function automatic logic [15:0] limit_sel();
		return rate_ff ? F_HARM_HI : F_HARM_LO;
	endfunction

	// Harmonic decision from upstream sharpness counts
	function automatic logic harm_now();
		logic [8:0] s;
		s = 9'(sharp_lo_cnt) + 9'(sharp_hi_cnt);
		if (rate_ff)
			return (mode_count < HARM_CNT_LIM && s >= HARM_SUM_HI && sharp_hi_cnt > HARM_HI_HI)
				|| mode_count >= HARM_CNT_LIM;
		return mode_count < HARM_CNT_LIM && s >= HARM_SUM_LO && sharp_hi_cnt > HARM_HI_LO;
	endfunction

	// Peak mode decision, super-wideband only
	function automatic logic pvq_now();
		return swb_ff && n_sharp_ff > (rate_ff ? TS_HI : TS_LO) && npk_ff <= (rate_ff ? TP_HI : TP_LO)
			&& d_sharp_ff > TD_Q4;
	endfunction

	// Frame capture, trackers and band accumulation
	always_ff @(posedge mclk) begin
		if (srst) begin
			rate_ff <= 1'b0;
			swb_ff <= 1'b0;
			ne_trk_ff <= TRK_INIT;
			pe_trk_ff <= TRK_INIT;
			ne_sum_ff <= 21'h0;
			pe_sum_ff <= 21'h0;
			bmax_ff <= 16'h0;
		end else if (st_ff == ST_IDLE && frame_start) begin
			rate_ff <= rate_hi;
			swb_ff <= super_wideband;
			ne_trk_ff <= TRK_INIT;
			pe_trk_ff <= TRK_INIT;
			ne_sum_ff <= 21'h0;
			pe_sum_ff <= 21'h0;
			bmax_ff <= 16'h0;
		end else if (coef_take) begin
			mag_mem[idx_ff] <= coef_mag;
			neg_mem[idx_ff] <= coef_neg;
			ne_trk_ff <= nxt_ne;
			pe_trk_ff <= nxt_pe;
			// Band closes every 32 bins, sums restart
			if (idx_ff[4:0] == 5'h1F) begin
				ne_band[idx_ff[8:5]] <= 16'((ne_sum_ff + 21'(nxt_ne)) >> 5);
				pe_band[idx_ff[8:5]] <= 16'((pe_sum_ff + 21'(nxt_pe)) >> 5);
				xmax_band[idx_ff[8:5]] <= (coef_mag > bmax_ff) ? coef_mag : bmax_ff;
				ne_sum_ff <= 21'h0;
				pe_sum_ff <= 21'h0;
				bmax_ff <= 16'h0;
			end else begin
				ne_sum_ff <= ne_sum_ff + 21'(nxt_ne);
				pe_sum_ff <= pe_sum_ff + 21'(nxt_pe);
				bmax_ff <= (coef_mag > bmax_ff) ? coef_mag : bmax_ff;
			end
		end
	end

	// Norm capture
	always_ff @(posedge mclk) begin
		if (norm_take) begin
			nrg_mem[idx_ff[4:0]] <= norm_energy;
			nq_mem[idx_ff[4:0]] <= norm_q;
		end
	end

	// Per-band threshold and sharpness, one band a cycle
	always_ff @(posedge mclk) begin
		logic [12:0] lp;
		logic signed [14:0] dl;
		logic signed [23:0] sc;
		logic signed [14:0] ex;
		logic [19:0] sh;
		lp = pmc_lg2({8'h00, pe_band[band_ff]});
		dl = 15'(signed'({2'b00, lp})) - 15'(signed'({2'b00, pmc_lg2({8'h00, ne_band[band_ff]})}));
		sc = (24'(dl) * 24'(signed'({1'b0, THR_EXP_Q8}))) >>> 8;
		ex = 15'(signed'({2'b00, lp})) + 15'(sc);
		sh = 20'((20'(xmax_band[band_ff]) << 4) / ((ne_band[band_ff] == 16'h0) ? 20'h1 : 20'(ne_band[band_ff])));
		if (srst || st_ff == ST_IDLE) begin
			band_ff <= 4'h0;
			n_sharp_ff <= 4'h0;
			d_sharp_ff <= 20'sh0;
		end else if (st_ff == ST_BAND) begin
			band_ff <= band_ff + 4'd1;
			for (int i = 0; i < BAND_LEN; i++)
				thr_mem[{band_ff, 5'(i)}] <= pmc_ex2(ex[14] ? 13'h0 : ex[12:0]);
			if (sh > SHARP_LIM_Q4) n_sharp_ff <= n_sharp_ff + 4'd1;
			d_sharp_ff <= d_sharp_ff + signed'(sh) - signed'(SHARP_LIM_Q4);
		end else if (st_ff == ST_PLACE && found_ff && npk_ff < 6'(MAX_PEAKS)) begin
			// Neighbour thresholds rescaled around the extracted peak
			for (int d = -2; d <= 2; d++)
				if (int'(best_pos_ff) + d >= 0 && int'(best_pos_ff) + d < LEN_HI)
					thr_mem[9'(int'(best_pos_ff) + d)] <= 24'((40'(thr_mem[9'(int'(best_pos_ff) + d)])
						* 40'((d == 0) ? SC_250 : (d == 1 || d == -1) ? SC_500 : SC_707)) >> 15);
		end
	end

	// Noise-floor and peak gains from band-average halves
	always_ff @(posedge mclk) begin
		logic [19:0] a0, a1, b0, b1;
		logic [3:0] h;
		a0 = 20'h0;
		a1 = 20'h0;
		b0 = 20'h0;
		b1 = 20'h0;
		h = nb >> 1;
		for (int b = 0; b < NB_HI; b++) begin
			if (4'(b) < h) begin
				a0 = a0 + 20'(ne_band[b]);
				b0 = b0 + 20'(pe_band[b]);
			end else if (4'(b) < nb) begin
				a1 = a1 + 20'(ne_band[b]);
				b1 = b1 + 20'(pe_band[b]);
			end
		end
		if (srst) begin
			noise_floor_gain0 <= 16'h0;
			noise_floor_gain1 <= 16'h0;
			peak_energy_gain0 <= 16'h0;
			peak_energy_gain1 <= 16'h0;
		end else if (st_ff == ST_GAIN) begin
			noise_floor_gain0 <= 16'(a0 / 20'(h));
			noise_floor_gain1 <= 16'(a1 / 20'(nb - h));
			peak_energy_gain0 <= 16'(b0 / 20'(h));
			peak_energy_gain1 <= 16'(b1 / 20'(nb - h));
		end
	end

	// Peak extraction, strongest remaining candidate each pass
	always_ff @(posedge mclk) begin
		if (srst || st_ff == ST_IDLE) begin
			picked_ff <= '0;
			npk_ff <= 6'h0;
			found_ff <= 1'b0;
			best_val_ff <= 16'h0;
			best_pos_ff <= 9'h0;
		end else if (st_ff == ST_SCAN) begin
			if (!picked_ff[idx_ff] && 24'(mag_mem[idx_ff]) > thr_mem[idx_ff]
				&& mag_mem[idx_ff] >= best_val_ff) begin
				found_ff <= 1'b1;
				best_val_ff <= mag_mem[idx_ff];
				best_pos_ff <= idx_ff;
			end
		end else if (st_ff == ST_PLACE) begin
			found_ff <= 1'b0;
			best_val_ff <= 16'h0;
			if (found_ff && npk_ff < 6'(MAX_PEAKS)) begin
				picked_ff[best_pos_ff] <= 1'b1;
				npk_ff <= npk_ff + 6'd1;
			end
		end
	end

	// Band-energy limitation search
	always_ff @(posedge mclk) begin
		logic [28:0] s10, s28;
		s10 = 29'h0;
		s28 = 29'h0;
		for (int b = 0; b < 28; b++) begin
			if (b < 10) s10 = s10 + 29'(nrg_mem[b]);
			s28 = s28 + 29'(nrg_mem[b]);
		end
		if (srst) begin
			el_ff <= 29'h0;
			et_ff <= 29'h0;
			hb_ff <= NORM_FIRST;
		end else if (st_ff == ST_PLACE) begin
			el_ff <= s10;
			et_ff <= s28;
			hb_ff <= NORM_FIRST;
		end else if (st_ff == ST_HARM && hb_ff <= NORM_LAST
			&& (44'(el_ff) << 15) < 44'(et_ff) * 44'(limit_sel())) begin
			el_ff <= el_ff + 29'(nrg_mem[hb_ff]);
			hb_ff <= hb_ff + 5'd1;
		end
	end

	// Decision outputs and scheme cost
	always_ff @(posedge mclk) begin
		logic [7:0] g;
		g = 8'h0;
		for (int k = 0; k < LEN_HI / GRP_LEN; k++)
			if (|picked_ff[k * GRP_LEN +: GRP_LEN]) g = g + 8'd1;
		if (srst) begin
			frame_mode <= MODE_GENERIC;
			limit_factor <= Q15_ONE;
			top_band <= NORM_LAST;
			peak_count <= 6'h0;
			grp_cnt_ff <= 8'h0;
			sparse_sel <= 1'b0;
		end else if (st_ff == ST_DEC) begin
			frame_mode <= pvq_now() ? MODE_PEAKVQ : harm_now() ? MODE_HARMONIC : MODE_GENERIC;
			limit_factor <= (!pvq_now() && harm_now()) ? limit_sel() : Q15_ONE;
			top_band <= (!pvq_now() && harm_now()) ? ((hb_ff > NORM_LAST) ? NORM_LAST : hb_ff) : NORM_LAST;
			peak_count <= npk_ff;
			grp_cnt_ff <= g;
			sparse_sel <= 1'b0;
		end else if (st_ff == ST_COST && idx_ff == len - 9'd1) begin
			// Cheaper scheme, sparse forced by an uncodable gap
			sparse_sel <= (cost_d_ff > 16'(last_grp) + 16'd1 + 16'(grp_cnt_ff) * 16'd3)
				|| gap_max_ff > GAP_MAX;
		end
	end

	// Delta cost estimate and running position state
	always_ff @(posedge mclk) begin
		logic [8:0] dv;
		logic [3:0] bl;
		dv = first_ff ? idx_ff : idx_ff - prev_pos_ff - D_OFFSET;
		bl = 4'h0;
		for (int i = 0; i < 9; i++) if (dv[i]) bl = 4'(i + 1);
		if (srst || st_ff == ST_DEC || (st_ff == ST_COST && idx_ff == len - 9'd1)) begin
			cost_d_ff <= 16'h0;
			gap_max_ff <= 9'h0;
			prev_pos_ff <= 9'h0;
			prev_q_ff <= 5'h0;
			first_ff <= 1'b1;
		end else if (st_ff == ST_COST && picked_ff[idx_ff]) begin
			cost_d_ff <= cost_d_ff + 16'({bl, 1'b1});
			if (!first_ff && idx_ff - prev_pos_ff > gap_max_ff) gap_max_ff <= idx_ff - prev_pos_ff;
			prev_pos_ff <= idx_ff;
			first_ff <= 1'b0;
		end else if (st_ff == ST_EMITP && picked_ff[idx_ff] && in_ready) begin
			prev_pos_ff <= idx_ff;
			prev_q_ff <= gq();
			first_ff <= 1'b0;
		end
	end

	// Quarter-scaled gain, 5-bit log index
	function automatic logic [4:0] gq();
		logic [12:0] l;
		l = pmc_lg2({8'h00, mag_mem[idx_ff] >> GAIN_SH});
		return (l[12:7] > 6'(GQ_MAX)) ? GQ_MAX : l[11:7];
	endfunction

	// Code words in ascending position, then groups
	always_comb begin
		logic [21:0] rec;
		logic [8:0] dv;
		rec = 22'(pmc_ex2({1'b0, gq(), 7'h00})) << GAIN_SH;
		dv = first_ff ? idx_ff : idx_ff - prev_pos_ff - D_OFFSET;
		in_valid = 1'b0;
		in_data = '0;
		if (st_ff == ST_EMITP && picked_ff[idx_ff]) begin
			in_valid = 1'b1;
			in_data = {1'b0, idx_ff, !neg_mem[idx_ff], 6'(gq()) - 6'(prev_q_ff), dv, rec};
		end else if (st_ff == ST_EMITG) begin
			in_valid = 1'b1;
			in_data = {1'b1, idx_ff, |picked_ff[idx_ff * 9'd5 +: GRP_LEN],
				grp_code(picked_ff[idx_ff * 9'd5 +: GRP_LEN]), 34'h0};
		end
	end

	// Two-entry output buffer
	logic [CODE_W-1:0] buf_mem [2];
	logic wr_ff, rd_ff;
	logic [1:0] cnt_ff;
	assign in_ready = (cnt_ff != 2'd2);
	assign code_valid = (cnt_ff != 2'd0);
	assign code_data = buf_mem[rd_ff];
	always_ff @(posedge mclk) begin
		if (srst) begin
			wr_ff <= 1'b0;
			rd_ff <= 1'b0;
			cnt_ff <= 2'd0;
		end else begin
			if (in_valid && in_ready) begin
				buf_mem[wr_ff] <= in_data;
				wr_ff <= !wr_ff;
			end
			if (code_valid && code_ready) rd_ff <= !rd_ff;
			cnt_ff <= cnt_ff + 2'(in_valid && in_ready) - 2'(code_valid && code_ready);
		end
	end

	// Done pulse and adjusted norm readback
	always_ff @(posedge mclk) begin
		if (srst) begin
			frame_done <= 1'b0;
			norm_rd_q <= 5'h0;
		end else begin
			frame_done <= (st_ff == ST_DONE);
			norm_rd_q <= (frame_mode == MODE_HARMONIC && norm_rd_idx >= (top_band >> 1)
				&& norm_rd_idx <= top_band) ? nq_mem[(top_band >> 1) - 5'd1]
				: nq_mem[(norm_rd_idx > NORM_LAST) ? NORM_LAST : norm_rd_idx];
		end
	end

	default clocking cb @(posedge mclk); endclocking
	default disable iff (srst);
	trk_preset_a: assert property (st_ff == ST_IDLE && frame_start |=> ne_trk_ff == TRK_INIT && pe_trk_ff == TRK_INIT) else $error("trackers not preset");
	harm_low_a: assert property (st_ff == ST_DEC && !rate_ff && !pvq_now() && harm_now() |=> frame_mode == MODE_HARMONIC && limit_factor == F_HARM_LO) else $error("low rate harmonic missed");
	harm_high_a: assert property (st_ff == ST_DEC && rate_ff && !pvq_now() && mode_count >= HARM_CNT_LIM |=> frame_mode == MODE_HARMONIC && limit_factor == F_HARM_HI) else $error("high rate harmonic missed");
	pvq_select_a: assert property (st_ff == ST_DEC && !swb_ff |=> frame_mode != MODE_PEAKVQ) else $error("peak mode without swb");
	peak_cap_a: assert property (st_ff == ST_PLACE && found_ff && npk_ff < 6'(MAX_PEAKS) |=> picked_ff[$past(best_pos_ff)] && npk_ff == $past(npk_ff) + 6'd1) else $error("peak not recorded");
	gap_force_a: assert property (st_ff == ST_COST && idx_ff == len - 9'd1 && gap_max_ff > GAP_MAX |=> sparse_sel) else $error("gap did not force sparse");
	sign_bit_a: assert property (in_valid && !in_data[CODE_W-1] |-> in_data[37] == !neg_mem[in_data[46:38]]) else $error("sign bit wrong");
	buf_full_a: assert property (cnt_ff == 2'd2 && !code_ready |=> code_valid && $stable(code_data)) else $error("buffer lost word");
	done_pulse_a: assert property (frame_done |=> !frame_done ##0 st_ff == ST_IDLE) else $error("done not a pulse");
	pvq_frame_c: cover property (st_ff == ST_DONE && frame_mode == MODE_PEAKVQ);
	sparse_frame_c: cover property (st_ff == ST_EMITG && sparse_sel);
	harm_frame_c: cover property (frame_done && frame_mode == MODE_HARMONIC);
endmodule
`default_nettype wire

// ### hw/pmc_pkg.sv
// Constants, types and helpers of the peak mode classifier coder
package pmc_pkg;
	localparam int MAG_W = 16;
	localparam int LEN_LO = 224;
	localparam int LEN_HI = 320;
	localparam int BAND_LEN = 32;
	localparam int NB_LO = 7;
	localparam int NB_HI = 10;
	localparam logic [15:0] TRK_INIT = 16'h0320;
	localparam logic [15:0] NE_W_UP = 16'h7A99;
	localparam logic [15:0] NE_W_DN = 16'h52D7;
	localparam logic [15:0] PE_W_UP = 16'h360E;
	localparam logic [15:0] PE_W_DN = 16'h66C5;
	localparam logic [15:0] Q15_ONE = 16'h8000;
	localparam logic [15:0] SC_707 = 16'h5A82;
	localparam logic [15:0] SC_500 = 16'h4000;
	localparam logic [15:0] SC_250 = 16'h2000;
	localparam logic [8:0] THR_EXP_Q8 = 9'h0E1;
	localparam logic [19:0] SHARP_LIM_Q4 = 20'h00090;
	localparam logic [3:0] TS_LO = 4'h4;
	localparam logic [3:0] TS_HI = 4'h7;
	localparam logic [5:0] TP_LO = 6'h14;
	localparam logic [5:0] TP_HI = 6'h17;
	localparam logic signed [19:0] TD_Q4 = 20'sh00160;
	localparam logic [7:0] HARM_CNT_LIM = 8'h05;
	localparam logic [8:0] HARM_SUM_LO = 9'h005;
	localparam logic [8:0] HARM_SUM_HI = 9'h00A;
	localparam logic [7:0] HARM_HI_LO = 8'h02;
	localparam logic [7:0] HARM_HI_HI = 8'h05;
	localparam logic [15:0] F_HARM_LO = 16'h7148;
	localparam logic [15:0] F_HARM_HI = 16'h7894;
	localparam int NORM_CNT = 29;
	localparam logic [4:0] NORM_FIRST = 5'h0A;
	localparam logic [4:0] NORM_LAST = 5'h1C;
	localparam logic [8:0] D_OFFSET = 9'h003;
	localparam logic [8:0] GAP_MAX = 9'h033;
	localparam int GRP_LEN = 5;
	localparam logic [4:0] GQ_MAX = 5'h1F;
	localparam int GAIN_SH = 2;
	localparam int MAX_PEAKS_DEF = 32;
	localparam int CODE_W = 48;

	typedef enum logic [1:0] {MODE_GENERIC, MODE_HARMONIC, MODE_PEAKVQ} pmc_mode_e;

	// Log2 in Q8, leading one plus linear fraction
	function automatic logic [12:0] pmc_lg2(input logic [23:0] x);
		logic [4:0] p;
		logic [23:0] n;
		p = 5'h00;
		for (int i = 0; i < 24; i++) if (x[i]) p = 5'(i);
		n = x << (5'd23 - p);
		return {p, n[22:15]};
	endfunction

	// Inverse of the above, saturating
	function automatic logic [23:0] pmc_ex2(input logic [12:0] e);
		logic [31:0] m;
		m = {23'h0, 1'b1, e[7:0]} << e[12:8];
		return (e[12:8] > 5'd23) ? 24'hFFFFFF : m[31:8];
	endfunction
endpackage

// ### testbench/pmc_far_model.sv
// Upstream coefficient/norm source and downstream code word sink
`timescale 1ns/1ns
`default_nettype none
module pmc_far_model (
	// Clock, reset and frame setup
	input wire logic mclk,
	input wire logic srst,
	input wire logic frame_start,
	input wire logic rate_hi,
	input wire logic [1:0] spiky,
	// Coefficient and norm source
	input wire logic coef_ready,
	output logic coef_valid,
	output logic [pmc_pkg::MAG_W-1:0] coef_mag,
	output logic coef_neg,
	input wire logic norm_ready,
	output logic norm_valid,
	output logic [23:0] norm_energy,
	output logic [4:0] norm_q,
	// Code word sink
	input wire logic code_valid,
	output logic code_ready,
	input wire logic [pmc_pkg::CODE_W-1:0] code_data
);
	import pmc_pkg::*;
	logic [8:0] ci_ff;
	logic [4:0] ni_ff;
	logic [3:0] cyc_ff;
	logic [15:0] spk;
	logic [CODE_W-1:0] got[$];
	// Spikes of varied size so energy order differs from position order
	always_comb begin
		case (ci_ff)
			9'd16: spk = 16'h4000;
			9'd48: spk = 16'h0800;
			9'd80: spk = 16'h2000;
			9'd112: spk = 16'h1000;
			9'd144: spk = 16'h0800;
			9'd208: spk = spiky[1] ? 16'h0064 : 16'h1000;
			default: spk = 16'h0064;
		endcase
	end
	// Idle lines except norm_q carry a running pattern so stale data never matches
	assign coef_valid = ci_ff < (rate_hi ? 9'(LEN_HI) : 9'(LEN_LO));
	assign coef_mag = !coef_valid ? {12'hA5A, cyc_ff} : spiky[0] ? spk : 16'h0064;
	assign coef_neg = coef_valid ? ci_ff[5] : cyc_ff[0];
	assign norm_valid = ni_ff < 5'd29;
	assign norm_energy = norm_valid ? 24'h000100 : {20'h5A5A5, cyc_ff};
	assign norm_q = ni_ff;
	// Sink stalls half of every 16 cycles, long enough to fill the buffer
	assign code_ready = ~cyc_ff[3];
	// Plain process, the bench empties the word queue between frames
	always @(posedge mclk) begin
		cyc_ff <= srst ? 4'h0 : cyc_ff + 4'h1;
		if (srst) begin
			ci_ff <= 9'h1FF;
			ni_ff <= 5'h1F;
		end else if (frame_start) begin
			ci_ff <= 9'h000;
			ni_ff <= 5'h00;
		end else begin
			if (coef_valid && coef_ready) ci_ff <= ci_ff + 9'h001;
			if (norm_valid && norm_ready) ni_ff <= ni_ff + 5'h01;
			if (code_valid && code_ready) got.push_back(code_data);
		end
	end
endmodule
`default_nettype wire

// ### testbench/testbench.sv
// Self-checking bench for the peak mode classifier coder
`timescale 1ns/1ns
`default_nettype none
module testbench;
	import pmc_pkg::*;
	logic mclk, srst, frame_start, rate_hi, super_wideband;
	logic [1:0] spiky;
	logic [7:0] mode_count, sharp_lo_cnt, sharp_hi_cnt;
	logic coef_valid, coef_ready, coef_neg, norm_valid, norm_ready;
	logic [MAG_W-1:0] coef_mag;
	logic [23:0] norm_energy;
	logic [4:0] norm_q, norm_rd_idx, norm_rd_q, top_band;
	logic frame_done, sparse_sel, code_valid, code_ready;
	pmc_mode_e frame_mode;
	logic [15:0] limit_factor, noise_floor_gain0, noise_floor_gain1, peak_energy_gain0, peak_energy_gain1;
	logic [5:0] peak_count;
	logic [CODE_W-1:0] code_data;
	int fail_count = 0;
	int n_checks = 0;
	// Spike positions of the far model and their expected gain indices
	int spk_pos[6] = '{16, 48, 80, 112, 144, 208};
	int spk_gi[6] = '{24, 18, 22, 20, 18, 20};
	pmc_coder dut (.mclk, .srst, .frame_start, .rate_hi, .super_wideband, .mode_count, .sharp_lo_cnt,
		.sharp_hi_cnt, .coef_valid, .coef_ready, .coef_mag, .coef_neg, .norm_valid, .norm_ready,
		.norm_energy, .norm_q, .frame_done, .frame_mode, .limit_factor, .top_band, .peak_count,
		.noise_floor_gain0, .noise_floor_gain1, .peak_energy_gain0, .peak_energy_gain1, .sparse_sel,
		.norm_rd_idx, .norm_rd_q, .code_valid, .code_ready, .code_data);
	pmc_far_model far (.mclk, .srst, .frame_start, .rate_hi, .spiky, .coef_ready, .coef_valid,
		.coef_mag, .coef_neg, .norm_ready, .norm_valid, .norm_energy, .norm_q, .code_valid,
		.code_ready, .code_data);
	initial begin
		mclk = 1'b0;
		forever #2 mclk = ~mclk;
	end
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	task automatic chk(input logic [47:0] got, input logic [47:0] exp);
		n_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	// A used-up bound ends the run at once
	task automatic tmo(input int n, input int lim);
		if (n >= lim) begin
			fail_count++;
			end_of_test();
		end
	endtask
	task automatic t_reset();
		@(posedge mclk);
		srst <= 1'b1;
		repeat (8) @(posedge mclk);
		srst <= 1'b0;
		@(posedge mclk) #1;
		chk({frame_done, code_valid, coef_ready, norm_ready, frame_mode, top_band, limit_factor},
			{4'h0, MODE_GENERIC, 5'h1C, Q15_ONE});
		chk(48'({noise_floor_gain0, noise_floor_gain1}), 48'h0);
		chk(48'({peak_energy_gain0, peak_energy_gain1}), 48'h0);
		$display("reset test done");
	endtask
	// Strobe one frame, then wait for its done pulse
	task automatic run_frame(input logic hi, sw, input logic [1:0] sp, input logic [7:0] mc, lo, hc);
		int n;
		@(posedge mclk);
		rate_hi <= hi;
		super_wideband <= sw;
		spiky <= sp;
		mode_count <= mc;
		sharp_lo_cnt <= lo;
		sharp_hi_cnt <= hc;
		frame_start <= 1'b1;
		@(posedge mclk);
		frame_start <= 1'b0;
		n = 0;
		while (frame_done !== 1'b1 && n < 40000) begin
			@(posedge mclk) #1;
			n++;
		end
		tmo(n, 40000);
	endtask
	// Registered norm readback, two edges after the index
	task automatic rd_norm(input logic [4:0] idx, input logic [4:0] exp);
		@(posedge mclk);
		norm_rd_idx <= idx;
		repeat (2) @(posedge mclk) #1;
		chk(48'(norm_rd_q), 48'(exp));
	endtask
	// Drain the sink, then check the first np peak words in position order
	task automatic peak_words(input int np);
		logic [8:0] p;
		logic [5:0] prv;
		int n;
		n = 0;
		while (code_valid !== 1'b0 && n < 50) begin
			@(posedge mclk) #1;
			n++;
		end
		tmo(n, 50);
		prv = 6'h00;
		for (int k = 0; k < np && k < far.got.size(); k++) begin
			p = 9'(spk_pos[k]);
			chk(far.got[k], {1'b0, p, ~p[5], 6'(spk_gi[k]) - prv, k ? p - 9'(spk_pos[k-1] + 3) : p,
				22'd4 << (spk_gi[k] / 2)});
			prv = 6'(spk_gi[k]);
		end
	endtask
	// Equal band energies stop the harmonic search at band 25 or 27
	task automatic t_class_lo();
		run_frame(1'b0, 1'b0, 2'b00, 8'h04, 8'h02, 8'h03);
		chk({frame_mode, limit_factor, top_band}, {MODE_HARMONIC, F_HARM_LO, 5'd25});
		// Flat input settles both trackers on it; only the first band still carries the preset
		chk({noise_floor_gain1, peak_energy_gain1, noise_floor_gain0 > 16'h0064, peak_energy_gain0 > 16'h0064},
			{16'h0064, 16'h0064, 2'b11});
		rd_norm(5'd20, 5'd11);
		rd_norm(5'd5, 5'd5);
		run_frame(1'b0, 1'b0, 2'b00, 8'h04, 8'h03, 8'h02);
		chk({frame_mode, limit_factor, top_band}, {MODE_GENERIC, Q15_ONE, 5'h1C});
		$display("class_lo test done");
	endtask
	task automatic t_class_hi();
		run_frame(1'b1, 1'b0, 2'b00, 8'h00, 8'h04, 8'h06);
		chk({frame_mode, limit_factor, top_band}, {MODE_HARMONIC, F_HARM_HI, 5'd27});
		run_frame(1'b1, 1'b0, 2'b00, 8'h05, 8'h00, 8'h00);
		chk({frame_mode, limit_factor}, {MODE_HARMONIC, F_HARM_HI});
		run_frame(1'b1, 1'b0, 2'b00, 8'h04, 8'h05, 8'h05);
		chk({frame_mode, limit_factor}, {MODE_GENERIC, Q15_ONE});
		$display("class_hi test done");
	endtask
	// Six spikes, one gap of 64 forces the sparse scheme
	task automatic t_peak();
		logic [2:0] cd;
		logic ct;
		far.got.delete();
		run_frame(1'b0, 1'b1, 2'b01, 8'h00, 8'h00, 8'h00);
		peak_words(6);
		chk({frame_mode, peak_count, sparse_sel}, {MODE_PEAKVQ, 6'h06, 1'b1});
		chk(48'(far.got.size()), 48'd51);
		for (int g = 0; g < 45 && g + 6 < far.got.size(); g++) begin
			ct = 1'b0;
			cd = 3'h0;
			foreach (spk_pos[k]) if (spk_pos[k] / 5 == g) begin
				ct = 1'b1;
				cd = 3'(spk_pos[k] % 5);
			end
			chk({far.got[g+6][47:37], ct ? far.got[g+6][36:34] : 3'h0}, {1'b1, 9'(g), ct, cd});
		end
		$display("peak test done");
	endtask
	// Five spikes 32 apart: delta coding is cheaper, no group words
	task automatic t_delta();
		far.got.delete();
		run_frame(1'b0, 1'b1, 2'b11, 8'h00, 8'h00, 8'h00);
		peak_words(5);
		chk({frame_mode, peak_count, sparse_sel}, {MODE_PEAKVQ, 6'h05, 1'b0});
		chk(48'(far.got.size()), 48'd5);
		$display("delta test done");
	endtask
	// Same spikes without super-wideband input never reach peak mode
	task automatic t_nosw();
		far.got.delete();
		run_frame(1'b0, 1'b0, 2'b01, 8'h00, 8'h00, 8'h00);
		repeat (20) @(posedge mclk);
		chk({frame_mode, 8'(far.got.size())}, {MODE_GENERIC, 8'h00});
		$display("no_swb test done");
	endtask
	initial begin
		srst = 1'b1;
		frame_start = 1'b0;
		{rate_hi, super_wideband, spiky, norm_rd_idx} = '0;
		{mode_count, sharp_lo_cnt, sharp_hi_cnt} = '0;
		t_reset();
		t_class_lo();
		t_class_hi();
		t_peak();
		t_delta();
		t_nosw();
		t_reset();
		end_of_test();
	end
endmodule
`default_nettype wire
